// File: rtl/bdbt_pkg.sv
package bdbt_pkg;
   // Host word width and host address width.
   localparam int DATA_W = 16;
   localparam int ADDR_W = 22;
   // Burst length, throttled burst length and gap time.
   localparam int BURST_WORDS = 16;
   localparam int THROTTLE_WORDS = 8;
   localparam int GAP_NS = 4000;
   localparam int CLK_PERIOD_NS = 40;
   localparam int GAP_CYCLES = (GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // Cache depth as address bits.
   localparam int CACHE_AW = 4;
   // Value of the host address counter after reset.
   localparam logic [ADDR_W-1:0] ADDR_RST = 22'h00_0000;
endpackage

// File: rtl/bdbt_buf_if.sv
`timescale 1ns/1ps
// Word stream between the cache side and the host bus side.
interface bdbt_buf_if;
   logic valid;
   logic ready;
   logic [bdbt_pkg::DATA_W-1:0] data;
   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface

// File: rtl/bdbt_skid.sv
`timescale 1ns/1ps
// Two-entry buffer; a receiver stall loses no word.
module bdbt_skid #(
   parameter int W = bdbt_pkg::DATA_W
) (
   // Clock and reset.
   input wire logic clock_i,
   input wire logic reset_n_i,
   // Filling and draining sides.
   bdbt_buf_if.snk in_if,
   bdbt_buf_if.src out_if
);
   logic [W-1:0] mem_ff [2];  // Entry storage.
   logic wr_ff;  // Write index.
   logic rd_ff;  // Read index.
   logic [1:0] cnt_ff;  // Entry count.
   logic push;
   logic pop;
   assign push = in_if.valid && in_if.ready;
   assign pop = out_if.valid && out_if.ready;
   assign in_if.ready = (cnt_ff != 2'h2);
   assign out_if.valid = (cnt_ff != 2'h0);
   assign out_if.data = mem_ff[rd_ff];
   // Storage is written only on an accepted word.
   always_ff @(posedge clock_i) begin
      if (push) begin
         mem_ff[wr_ff] <= in_if.data;
      end
   end
   // Pointers and count.
   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         wr_ff <= 1'b0;
         rd_ff <= 1'b0;
         cnt_ff <= 2'h0;
      end else begin
         if (push) begin
            wr_ff <= ~wr_ff;
         end
         if (pop) begin
            rd_ff <= ~rd_ff;
         end
         cnt_ff <= cnt_ff + {1'b0, push} - {1'b0, pop};
      end
   end
   a_buf_no_overrun: assert property (@(posedge clock_i) disable iff (!reset_n_i)
      cnt_ff <= 2'h2) else $error("buffer count above two");
endmodule

// File: rtl/bdbt_top.sv
`timescale 1ns/1ps
// Overview of operation
// - After sixteen words, release bus four microseconds.
// - Foreign DMA request ends burst after eight.
// - One address phase, then a data burst.
// - Master handshake per block mode, memory slaves.
// - Non-block memory falls back to single words.
// - Host addresses are twenty-two bits wide.
// - Host data always comes from the cache.
// - Drive fill and bus drain run concurrently.
module bdbt_top #(
   parameter int DW = bdbt_pkg::DATA_W,
   parameter int AW = bdbt_pkg::ADDR_W,
   parameter int CAW = bdbt_pkg::CACHE_AW
) (
   // Clock and reset.
   input wire logic clock_i,
   input wire logic reset_n_i,
   // Job control from firmware.
   input wire logic start_i,
   input wire logic [AW-1:0] start_addr_i,
   input wire logic [15:0] word_count_i,
   output logic busy_o,
   output logic done_o,
   // Drive side write port into the cache.
   input wire logic drv_we_i,
   input wire logic [CAW-1:0] drv_addr_i,
   input wire logic [DW-1:0] drv_data_i,
   // Host bus pins; the inputs are asynchronous to this clock, the outputs are registered on it.
   input wire logic bus_grant_i,
   input wire logic slave_reply_i,
   input wire logic block_ok_i,
   input wire logic other_dma_req_i,
   output logic bus_req_o,
   output logic addr_strobe_o,
   output logic data_strobe_o,
   output logic block_mode_o,
   output logic [AW-1:0] bus_addr_o,
   output logic [DW-1:0] bus_data_o
);
   typedef enum logic [2:0] {ST_IDLE, ST_REQ, ST_ADDR, ST_LOAD, ST_DATA, ST_GAP} bdbt_state_e;
   bdbt_state_e state_ff;
   // Cache memory, the only source of host data.
   logic [DW-1:0] cache_ff [2**CAW];
   logic [CAW-1:0] rd_idx_ff;  // Cache read index.
   // Three-stage synchronisers for the bus pins.
   logic [2:0] gnt_s_ff, rpl_s_ff, blk_s_ff, oth_s_ff;
   logic gnt, rpl, blk, oth;
   logic rpl_seen_ff;  // Reply level agreed in last cycle.
   logic gnt_seen_ff;  // Grant level agreed in last cycle.
   logic blk_seen_ff;  // Block capability level agreed in last cycle.
   logic oth_seen_ff;  // Foreign request level agreed in last cycle.
   logic [4:0] burst_cnt_ff;  // Words moved in this burst.
   logic [15:0] left_ff;  // Words still to move.
   logic [$clog2(bdbt_pkg::GAP_CYCLES+1)-1:0] gap_cnt_ff;
   logic throttle_ff;  // A foreign request was seen this burst.
   logic [AW-1:0] addr_ff;  // Next host word address.
   bdbt_buf_if fill_if();
   bdbt_buf_if bus_if();
   logic [15:0] fed_ff;  // Words still to push into the buffer.
   logic rpl_rise;
   logic burst_end;

   // Agreement of the second and third stages counts as a change.
   function automatic logic sync_level(input logic [2:0] s, input logic prev);
      sync_level = (s[1] == s[2]) ? s[1] : prev;
   endfunction

   // Pins cross into this clock; the first stage feeds only the second.
   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         gnt_s_ff <= 3'h0;
         rpl_s_ff <= 3'h0;
         blk_s_ff <= 3'h0;
         oth_s_ff <= 3'h0;
      end else begin
         gnt_s_ff <= {gnt_s_ff[1:0], bus_grant_i};
         rpl_s_ff <= {rpl_s_ff[1:0], slave_reply_i};
         blk_s_ff <= {blk_s_ff[1:0], block_ok_i};
         oth_s_ff <= {oth_s_ff[1:0], other_dma_req_i};
      end
   end
   // A pin keeps its last agreed level while stages two and three disagree.
   assign gnt = sync_level(gnt_s_ff, gnt_seen_ff);
   assign blk = sync_level(blk_s_ff, blk_seen_ff);
   assign oth = sync_level(oth_s_ff, oth_seen_ff);
   assign rpl = sync_level(rpl_s_ff, rpl_seen_ff);

   // Reply edge marks one word accepted by the memory slave.
   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         rpl_seen_ff <= 1'b0;
         gnt_seen_ff <= 1'b0;
         blk_seen_ff <= 1'b0;
         oth_seen_ff <= 1'b0;
      end else begin
         rpl_seen_ff <= rpl;
         gnt_seen_ff <= gnt;
         blk_seen_ff <= blk;
         oth_seen_ff <= oth;
      end
   end
   assign rpl_rise = rpl && !rpl_seen_ff;

   // Drive writes into the cache at any time, even mid transfer.
   always_ff @(posedge clock_i) begin
      if (drv_we_i) begin
         cache_ff[drv_addr_i] <= drv_data_i;
      end
   end

   // Cache words feed the buffer; bus transfer never stalls the drive port.
   assign fill_if.valid = (state_ff != ST_IDLE) && (fed_ff != 16'h0000);
   assign fill_if.data = cache_ff[rd_idx_ff];
   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         rd_idx_ff <= '0;
         fed_ff <= 16'h0000;
      end else if (start_i && state_ff == ST_IDLE) begin
         rd_idx_ff <= '0;
         fed_ff <= word_count_i;
      end else if (fill_if.valid && fill_if.ready) begin
         rd_idx_ff <= rd_idx_ff + 1'b1;
         fed_ff <= fed_ff - 16'h0001;
      end
   end

   bdbt_skid #(.W(DW)) u_skid (
      .clock_i(clock_i),
      .reset_n_i(reset_n_i),
      .in_if(fill_if),
      .out_if(bus_if)
   );

   // Burst ends at sixteen, or at eight after a foreign request.
   assign burst_end = (burst_cnt_ff == 5'(bdbt_pkg::BURST_WORDS - 1))
      || ((throttle_ff || oth) && burst_cnt_ff >= 5'(bdbt_pkg::THROTTLE_WORDS - 1))
      || !block_mode_o || (left_ff == 16'h0001);
   // The buffer drains only when a word is latched onto the bus.
   // A word waits while the last reply is still high, so none is popped twice.
   assign bus_if.ready = (state_ff == ST_LOAD) && !rpl;

   // Transfer sequencer, bus master side of the handshake.
   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         state_ff <= ST_IDLE;
         burst_cnt_ff <= 5'h00;
         left_ff <= 16'h0000;
         gap_cnt_ff <= '0;
         throttle_ff <= 1'b0;
         addr_ff <= bdbt_pkg::ADDR_RST;
      end else begin
         case (state_ff)
            ST_IDLE: begin
               if (start_i && word_count_i != 16'h0000) begin
                  addr_ff <= start_addr_i;
                  left_ff <= word_count_i;
                  state_ff <= ST_REQ;
               end
            end
            ST_REQ: begin
               burst_cnt_ff <= 5'h00;
               throttle_ff <= 1'b0;
               if (gnt && !rpl) begin
                  state_ff <= ST_ADDR;
               end
            end
            ST_ADDR: begin
               // One address reference opens the burst.
               if (rpl_rise) begin
                  state_ff <= ST_LOAD;
               end
            end
            ST_LOAD: begin
               // The next strobe waits for the reply to fall, or its edge is lost.
               if (bus_if.valid && !rpl) begin
                  state_ff <= ST_DATA;
               end
            end
            ST_DATA: begin
               if (oth) begin
                  throttle_ff <= 1'b1;
               end
               if (rpl_rise) begin
                  addr_ff <= addr_ff + 1'b1;
                  left_ff <= left_ff - 16'h0001;
                  burst_cnt_ff <= burst_cnt_ff + 5'h01;
                  if (burst_end) begin
                     gap_cnt_ff <= '0;
                     state_ff <= ST_GAP;
                  end else begin
                     state_ff <= ST_LOAD;
                  end
               end
            end
            ST_GAP: begin
               // Bus is released; others get their interrupts and DMA in.
               gap_cnt_ff <= gap_cnt_ff + 1'b1;
               if (left_ff == 16'h0000) begin
                  state_ff <= ST_IDLE;
               end else if (!block_mode_o) begin
                  state_ff <= ST_REQ;
               end else if (gap_cnt_ff == ($bits(gap_cnt_ff))'(bdbt_pkg::GAP_CYCLES - 1)) begin
                  state_ff <= ST_REQ;
               end
            end
            default: begin
               state_ff <= ST_IDLE;
            end
         endcase
      end
   end

   // Block mode sampled from memory at each address phase.
   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         block_mode_o <= 1'b0;
      end else if (state_ff == ST_ADDR && rpl_rise) begin
         block_mode_o <= blk;
      end
   end

   // Bus pins registered from state.
   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         bus_req_o <= 1'b0;
         addr_strobe_o <= 1'b0;
         data_strobe_o <= 1'b0;
         bus_addr_o <= '0;
         bus_data_o <= '0;
         busy_o <= 1'b0;
         done_o <= 1'b0;
      end else begin
         bus_req_o <= (state_ff == ST_REQ);
         addr_strobe_o <= (state_ff == ST_ADDR);
         data_strobe_o <= (state_ff == ST_DATA);
         bus_addr_o <= addr_ff;
         if (bus_if.valid && bus_if.ready) begin
            bus_data_o <= bus_if.data;
         end
         busy_o <= (state_ff != ST_IDLE);
         done_o <= (state_ff == ST_GAP) && (left_ff == 16'h0000);
      end
   end

   // A burst never counts past sixteen words.
   a_burst_max_len: assert property (@(posedge clock_i) disable iff (!reset_n_i)
      burst_cnt_ff <= 5'(bdbt_pkg::BURST_WORDS)) else $error("burst above sixteen words");
   // Once throttled, the eighth accepted word closes the burst.
   a_throttle_len_cap: assert property (@(posedge clock_i) disable iff (!reset_n_i)
      throttle_ff && state_ff == ST_DATA && rpl_rise && burst_cnt_ff >= 5'(bdbt_pkg::THROTTLE_WORDS - 1)
      |=> state_ff == ST_GAP) else $error("throttled burst above eight");
   // The bus stays released through the start of the pause.
   a_gap_no_request: assert property (@(posedge clock_i) disable iff (!reset_n_i)
      state_ff == ST_GAP && block_mode_o && left_ff != 16'h0000 && gap_cnt_ff == '0 |=> !bus_req_o [*8])
      else $error("bus requested inside gap");
   // No data strobe is raised while the previous reply is still high.
   a_load_waits_low: assert property (@(posedge clock_i) disable iff (!reset_n_i)
      state_ff == ST_LOAD && rpl |=> state_ff == ST_LOAD) else $error("strobe raised before reply fell");
   // Without block mode every accepted word ends the tenure.
   a_single_word_mode: assert property (@(posedge clock_i) disable iff (!reset_n_i)
      state_ff == ST_DATA && rpl_rise && !block_mode_o |=> state_ff == ST_GAP)
      else $error("single word mode kept the bus");
endmodule

// File: sim/bdbt_mem_model.sv
`timescale 1ns/1ps
// Host memory slave and bus arbiter; answers after wait_i extra cycles.
module bdbt_mem_model (
   // Clock, reset and behaviour knobs.
   input wire logic clock_i,
   input wire logic reset_n_i,
   input wire logic block_cap_i,
   input wire logic [3:0] wait_i,
   // Bus pins seen from the memory.
   input wire logic bus_req_i,
   input wire logic addr_strobe_i,
   input wire logic data_strobe_i,
   input wire logic [21:0] bus_addr_i,
   input wire logic [15:0] bus_data_i,
   output logic bus_grant_o,
   output logic slave_reply_o,
   output logic block_ok_o
);
   logic [15:0] mem [256]; // Stored words, indexed by the low address byte.
   logic [21:0] tag [256]; // Full host address that wrote each entry.
   logic [21:0] cur_addr; // Next word address within a burst.
   logic [3:0] wait_cnt; // Cycles waited before replying.
   // Block capability is a steady level of this memory.
   assign block_ok_o = block_cap_i;
   // Grant follows request; reply rises per strobe and falls once it drops.
   always @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         bus_grant_o <= 1'b0;
         slave_reply_o <= 1'b0;
         wait_cnt <= 4'h0;
         cur_addr <= 22'h00_0000;
      end else begin
         bus_grant_o <= bus_req_i;
         if ((addr_strobe_i || data_strobe_i) && !slave_reply_o) begin
            if (wait_cnt == wait_i) begin
               slave_reply_o <= 1'b1;
               wait_cnt <= 4'h0;
               if (addr_strobe_i) cur_addr <= bus_addr_i;
               else begin
                  mem[cur_addr[7:0]] <= bus_data_i;
                  tag[cur_addr[7:0]] <= cur_addr;
                  cur_addr <= cur_addr + 22'h00_0001;
               end
            end else wait_cnt <= wait_cnt + 4'h1;
         end else if (!addr_strobe_i && !data_strobe_i) slave_reply_o <= 1'b0;
      end
   end
endmodule

// File: sim/bdbt_top_tb.sv
`timescale 1ns/1ps
module bdbt_top_tb;
`define CHK(a, b) tests_run++; if ((a) !== (b)) begin errors++; $display("[ERR] %0t got %h exp %h", $time, a, b); end
   logic clock_i = 1'b0, reset_n_i = 1'b0, start_i = 1'b0, drv_we_i = 1'b0;
   logic [21:0] start_addr_i = 22'h00_0000;
   logic [15:0] word_count_i = 16'h0000, drv_data_i = 16'h0000;
   logic [3:0] drv_addr_i = 4'h0, wt = 4'h0;
   logic other_dma_req_i = 1'b0, cap = 1'b1;
   logic busy_o, done_o, bus_req_o, addr_strobe_o, data_strobe_o, block_mode_o;
   logic bus_grant_i, slave_reply_i, block_ok_i;
   logic [21:0] bus_addr_o;
   logic [15:0] bus_data_o;
   int errors = 0, tests_run = 0;
   // Bus monitor figures, cleared before each job.
   int data_cnt, addr_cnt, burst, max_burst, gap, min_gap;
   logic in_gap, bm_seen, ds_q, as_q, rq_q;
   initial forever #20 clock_i = ~clock_i;
   bdbt_top u_dut (.clock_i(clock_i), .reset_n_i(reset_n_i), .start_i(start_i), .start_addr_i(start_addr_i),
      .word_count_i(word_count_i), .busy_o(busy_o), .done_o(done_o), .drv_we_i(drv_we_i),
      .drv_addr_i(drv_addr_i), .drv_data_i(drv_data_i), .bus_grant_i(bus_grant_i),
      .slave_reply_i(slave_reply_i), .block_ok_i(block_ok_i), .other_dma_req_i(other_dma_req_i),
      .bus_req_o(bus_req_o), .addr_strobe_o(addr_strobe_o), .data_strobe_o(data_strobe_o),
      .block_mode_o(block_mode_o), .bus_addr_o(bus_addr_o), .bus_data_o(bus_data_o));
   bdbt_mem_model u_mem (.clock_i(clock_i), .reset_n_i(reset_n_i), .block_cap_i(cap), .wait_i(wt),
      .bus_req_i(bus_req_o), .addr_strobe_i(addr_strobe_o), .data_strobe_i(data_strobe_o),
      .bus_addr_i(bus_addr_o), .bus_data_i(bus_data_o), .bus_grant_o(bus_grant_i),
      .slave_reply_o(slave_reply_i), .block_ok_o(block_ok_i));
   // Cache pattern; word k of a job comes from index k modulo the depth.
   function automatic logic [15:0] pat(input int i);
      return 16'hA500 ^ 16'(i % 16);
   endfunction
   // Tenure lengths, address phases and the quiet time from a last word to the next request.
   always @(posedge clock_i) begin
      if (data_strobe_o && !ds_q) begin
         data_cnt++;
         burst++;
         if (burst > max_burst) max_burst = burst;
      end
      if (addr_strobe_o && !as_q) addr_cnt++;
      if (block_mode_o && data_strobe_o) bm_seen = 1'b1;
      if (!data_strobe_o && ds_q) begin
         in_gap = 1'b1;
         gap = 0;
      end else if (in_gap && !bus_req_o) gap++;
      if (bus_req_o && !rq_q) begin
         if (in_gap && gap < min_gap) min_gap = gap;
         in_gap = 1'b0;
         burst = 0;
      end
      ds_q = data_strobe_o;
      as_q = addr_strobe_o;
      rq_q = bus_req_o;
   end
   // Fills the cache from the drive side.
   task automatic fill();
      for (int i = 0; i < 16; i++) begin
         @(negedge clock_i);
         drv_we_i = 1'b1;
         drv_addr_i = 4'(i);
         drv_data_i = pat(i);
      end
      @(negedge clock_i) drv_we_i = 1'b0;
   endtask
   // Runs one job; a second start mid-job must be ignored; the drive refills meanwhile.
   task automatic run_job(input logic [21:0] a, input logic [15:0] n);
      {data_cnt, addr_cnt, burst, max_burst, min_gap} = {32'd0, 32'd0, 32'd0, 32'd0, 32'd9999};
      {in_gap, bm_seen} = 2'b00;
      @(negedge clock_i) {start_i, start_addr_i, word_count_i} = {1'b1, a, n};
      @(negedge clock_i) start_i = 1'b0;
      repeat (30) @(negedge clock_i);
      `CHK(busy_o, 1'b1)
      {start_i, word_count_i} = {1'b1, 16'h0002};
      @(negedge clock_i) start_i = 1'b0;
      fill();
      for (int c = 0; c < 20000 && !done_o; c++) @(negedge clock_i);
      `CHK(done_o, 1'b1)
      @(negedge clock_i);
      `CHK(busy_o, 1'b0)
      for (int k = 0; k < int'(n); k++) begin
         `CHK(u_mem.mem[8'(a + 22'(k))], pat(k))
         `CHK(u_mem.tag[8'(a + 22'(k))], a + 22'(k))
      end
      `CHK(data_cnt, int'(n))
   endtask
   // Block memory, prompt replies, 24 words near the top of the address space.
   task automatic t_block();
      {cap, wt, other_dma_req_i} = {1'b1, 4'h0, 1'b0};
      run_job(22'h3F_FF00, 16'h0018);
      `CHK(max_burst, 16)
      `CHK(addr_cnt, 2)
      `CHK(bm_seen, 1'b1)
      `CHK(min_gap >= bdbt_pkg::GAP_CYCLES - 10 && min_gap <= bdbt_pkg::GAP_CYCLES + 10, 1'b1)
   endtask
   // Foreign DMA request present and slow memory: bursts are cut at eight.
   task automatic t_throttle();
      {cap, wt, other_dma_req_i} = {1'b1, 4'h3, 1'b1};
      run_job(22'h01_2340, 16'h0010);
      `CHK(max_burst, 8)
      `CHK(addr_cnt, 2)
      `CHK(min_gap >= bdbt_pkg::GAP_CYCLES - 10 && min_gap <= bdbt_pkg::GAP_CYCLES + 10, 1'b1)
      other_dma_req_i = 1'b0;
   endtask
   // Memory without block mode: one address phase per word, never block mode.
   task automatic t_single();
      {cap, wt} = {1'b0, 4'h1};
      run_job(22'h20_0007, 16'h0005);
      `CHK(addr_cnt, 5)
      `CHK(bm_seen, 1'b0)
   endtask
   // Prints the counts and the verdict, then stops.
   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   // Three jobs of well under 2000 cycles each; this limit leaves a wide margin.
   initial begin
      #(40 * 60000);
      errors++;
      give_verdict();
   end
   initial begin
      repeat (2) @(negedge clock_i);
      reset_n_i = 1'b1;
      `CHK(bus_req_o, 1'b0)
      fill();
      t_block();
      t_throttle();
      t_single();
      give_verdict();
   end
endmodule
